// File: pfm_pkg.sv
// package: constants and types of the predictive failure monitor
package pfm_pkg;

  // ****************************************************************
  // clock and timing
  // ****************************************************************
  localparam int unsigned CLK_MHZ        = 200;
  localparam longint     PERIOD_S        = 7200;
  localparam longint     PERIOD_CYC      = PERIOD_S * 64'd1000000 * CLK_MHZ;
  localparam int unsigned RUN_LG_ONL_MS  = 150;
  localparam int unsigned RUN_LG_FULL_MS = 270;
  localparam int unsigned RUN_SM_ONL_MS  = 100;
  localparam int unsigned RUN_SM_FULL_MS = 190;
  localparam int unsigned RUN_LG_ONL_CYC  = RUN_LG_ONL_MS * 1000 * CLK_MHZ;
  localparam int unsigned RUN_LG_FULL_CYC = RUN_LG_FULL_MS * 1000 * CLK_MHZ;
  localparam int unsigned RUN_SM_ONL_CYC  = RUN_SM_ONL_MS * 1000 * CLK_MHZ;
  localparam int unsigned RUN_SM_FULL_CYC = RUN_SM_FULL_MS * 1000 * CLK_MHZ;

  // ****************************************************************
  // widths, reset values and report code
  // ****************************************************************
  localparam int unsigned TMR_W      = 48;
  localparam int unsigned RUN_W      = 32;
  localparam int unsigned CNT_W      = 16;
  localparam int unsigned HIST_W     = 8;
  localparam logic [15:0] SENSE_CODE = 16'h5D00;
  localparam logic [7:0]  SENSE_KEY  = 8'h01;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  typedef enum logic [1:0] {
    PFM_IDLE,
    PFM_WAIT,
    PFM_RUN
  } pfm_state_t;

endpackage : pfm_pkg

// File: pfm_attr.sv
// file: error-rate counters of one monitored attribute
`timescale 1ns/1ps
module pfm_attr
  import pfm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // control
  input  wire logic              enable,
  input  wire logic [CNT_W-1:0]  interval_len,
  input  wire logic [CNT_W-1:0]  err_threshold,
  input  wire logic [HIST_W-1:0] pred_threshold,
  // events
  input  wire logic              op_event,
  input  wire logic              err_event,
  // results
  output logic                   interval_done,
  output logic [HIST_W-1:0]      history,
  output logic                   predict
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [CNT_W-1:0]  ops;
    logic [CNT_W-1:0]  errs;
    logic [HIST_W-1:0] hist;
    logic              done;
    logic              pred;
  } pfm_attr_st_t;

  pfm_attr_st_t s_r, s_nxt;
  logic [CNT_W-1:0] ops_inc;
  logic [CNT_W-1:0] errs_inc;
  logic             bad;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    ops_inc    = s_r.ops + (op_event ? 16'h0001 : 16'h0000);
    errs_inc   = (err_event && s_r.errs != 16'hFFFF) ? s_r.errs + 16'h0001 : s_r.errs;
    bad        = errs_inc > err_threshold;                          // R12
    if (enable) begin
      s_nxt.ops  = ops_inc;                                         // R10
      s_nxt.errs = errs_inc;                                        // R11
      if (op_event && ops_inc >= interval_len) begin
        s_nxt.done = 1'b1;
        s_nxt.ops  = CNT_RST;                                       // R13
        s_nxt.errs = CNT_RST;                                       // R13
        if (bad) begin
          if (s_r.hist != 8'hFF)
            s_nxt.hist = s_r.hist + 8'h01;                          // R14
        end else if (s_r.hist != 8'h00) begin
          s_nxt.hist = s_r.hist - 8'h01;                            // R14
        end
      end
    end
    // latched predictive failure is sticky until rst_n resets the block
    if (s_nxt.hist >= pred_threshold && pred_threshold != 8'h00)
      s_nxt.pred = 1'b1;                                            // R15
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign interval_done = s_r.done;
  assign history       = s_r.hist;
  assign predict       = s_r.pred;

  // ****************************************************************
  // checks
  // ****************************************************************
  // acceptable interval with empty history must leave it at zero, not wrap
  chk_hist_floor: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.hist == 8'h00 && enable && op_event && ops_inc >= interval_len && !bad)
      |=> s_r.hist == 8'h00) // R14
    else $error("history went below zero");
  chk_interval_clear: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.done |-> s_r.ops == CNT_RST && s_r.errs == CNT_RST) // R13
    else $error("counters not cleared after interval");
  chk_pred_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    s_r.pred |=> s_r.pred) // R15
    else $error("predictive failure dropped");
  chk_disabled_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> $stable(s_r.ops) && $stable(s_r.hist)) // R1
    else $error("counters moved while disabled");

endmodule : pfm_attr

// File: pfm_top.sv
// file: predictive failure monitor top
//
// What this block does
// R1 - exceptions-disable bit set suspends monitoring, run scheduling and reporting; an off-line run already in progress still runs to its end
// R2 - on-line data gathered from normal read/write traffic while enabled
// R3 - online-only bit set: no off-line measurement run starts; a run already in progress completes
// R4 - rezero forces a run now and restarts the two-hour timer
// R5 - time left to next scheduled run is readable for the log query
// R6 - scheduled run every two hours, started only when bus is idle
// R7 - run is uninterruptible; length 150/270 ms large, 100/190 ms small; every run here counts down RUN_FULL, RUN_ONL is unused
// R8 - predictive failure reports the fixed failure-prediction sense code
// R9 - latched failure report survives bus reset and power cycle
// R10 - per attribute, interval counter counts operations up to interval length
// R11 - per attribute, failure counter counts errors within the interval
// R12 - errors above threshold make the interval unacceptable, else acceptable
// R13 - both counters cleared after each classified interval
// R14 - history up on unacceptable, down on acceptable, never below zero
// R15 - history reaching predictive threshold signals predictive failure
// R16 - each attribute has its own history counter
// R17 - timer reloads with the two-hour period after each scheduled run
`timescale 1ns/1ps
module pfm_top
  import pfm_pkg::*;
#(
  parameter int unsigned     N_ATTR      = 4,
  parameter logic [TMR_W-1:0] PERIOD     = TMR_W'(PERIOD_CYC),
  parameter logic [RUN_W-1:0] RUN_ONL    = RUN_W'(RUN_LG_ONL_CYC),
  parameter logic [RUN_W-1:0] RUN_FULL   = RUN_W'(RUN_LG_FULL_CYC)
)(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // mode page bits
  input  wire logic                     exceptions_disable_bit,
  input  wire logic                     online_only_bit,
  input  wire logic                     report_enable,
  input  wire logic [CNT_W-1:0]         interval_len,
  input  wire logic [CNT_W-1:0]         err_threshold,
  input  wire logic [HIST_W-1:0]        pred_threshold,
  // host commands and bus state (pins)
  input  wire logic                     rezero_command,
  input  wire logic                     bus_idle,
  // on-line traffic from the data path (same clock)
  input  wire logic [N_ATTR-1:0]        op_event,
  input  wire logic [N_ATTR-1:0]        err_event,
  // non-volatile failure latch
  input  wire logic                     nv_fail_in,
  output logic                          nv_fail_set,
  // off-line run
  output logic                          run_busy,
  output logic                          save_strobe,
  // host report
  output logic [TMR_W-1:0]              time_to_run,
  output logic                          sense_valid,
  output logic [7:0]                    sense_key,
  output logic [15:0]                   sense_code,
  output logic [N_ATTR*HIST_W-1:0]      history_out
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] pins;

  assign pins = {rezero_command, bus_idle, nv_fail_in};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
    end else begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  logic rz_s;
  logic idle_s;
  logic nv_s;
  assign rz_s   = sync2_r[2];
  assign idle_s = sync2_r[1];
  assign nv_s   = sync2_r[0];

  // ****************************************************************
  // per-attribute counters
  // ****************************************************************
  logic              mon_en;
  logic [N_ATTR-1:0] attr_pred;
  logic [N_ATTR-1:0] attr_done;

  assign mon_en = !exceptions_disable_bit;                          // R1

  for (genvar g = 0; g < N_ATTR; g++) begin : g_attr
    pfm_attr u_attr (                                               // R16
      .clk            (clk),
      .rst_n          (rst_n),
      .enable         (mon_en),                                     // R2
      .interval_len   (interval_len),
      .err_threshold  (err_threshold),
      .pred_threshold (pred_threshold),
      .op_event       (op_event[g]),
      .err_event      (err_event[g]),
      .interval_done  (attr_done[g]),
      .history        (history_out[g*HIST_W +: HIST_W]),
      .predict        (attr_pred[g])
    );
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pfm_state_t        st;
    logic [TMR_W-1:0]  tmr;
    logic [RUN_W-1:0]  run;
    logic              rz_d;
    logic              forced;
    logic              save;
    logic              fail;
    logic              nvset;
  } pfm_top_st_t;

  pfm_top_st_t s_r, s_nxt;
  logic        rz_pulse;

  assign rz_pulse = rz_s && !s_r.rz_d;

  always_comb begin
    s_nxt       = s_r;
    s_nxt.rz_d  = rz_s;
    s_nxt.save  = 1'b0;
    s_nxt.nvset = 1'b0;
    // failure latch: reloaded from non-volatile copy so it outlives resets
    if (nv_s)
      s_nxt.fail = 1'b1;                                            // R9
    if (mon_en && |attr_pred && !s_r.fail) begin
      s_nxt.fail  = 1'b1;
      s_nxt.nvset = 1'b1;                                           // R9
    end
    unique case (s_r.st)
      PFM_IDLE: begin
        if (mon_en && !online_only_bit) begin
          if (s_r.tmr != '0)
            s_nxt.tmr = s_r.tmr - 1'b1;
          if (rz_pulse) begin
            s_nxt.tmr    = PERIOD;                                  // R4
            s_nxt.forced = 1'b1;
            s_nxt.st     = PFM_RUN;                                 // R4
            s_nxt.run    = RUN_FULL;
          end else if (s_r.tmr == '0) begin
            s_nxt.st = PFM_WAIT;                                    // R6
          end
        end
      end
      PFM_WAIT: begin
        if (!mon_en || online_only_bit) begin
          s_nxt.st = PFM_IDLE;                                      // R3
        end else if (rz_pulse || idle_s) begin
          s_nxt.forced = rz_pulse;
          s_nxt.tmr    = PERIOD;                                    // R4
          s_nxt.run    = RUN_FULL;
          s_nxt.st     = PFM_RUN;                                   // R6
        end
      end
      PFM_RUN: begin
        // no exit until the worst-case length has elapsed
        if (s_r.run != '0) begin
          s_nxt.run = s_r.run - 1'b1;                               // R7
        end else begin
          s_nxt.save   = 1'b1;
          s_nxt.forced = 1'b0;
          s_nxt.tmr    = PERIOD;                                    // R17
          s_nxt.st     = PFM_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_r     <= '0;
      s_r.tmr <= PERIOD;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign run_busy    = (s_r.st == PFM_RUN);
  assign save_strobe = s_r.save;
  assign nv_fail_set = s_r.nvset;
  assign time_to_run = s_r.tmr;                                     // R5
  // reporting is held off while disabled or when the method is off
  assign sense_valid = s_r.fail && mon_en && report_enable;         // R8
  assign sense_key   = sense_valid ? SENSE_KEY : 8'h00;             // R8
  assign sense_code  = sense_valid ? SENSE_CODE : 16'h0000;         // R8

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_start_run;
    s_r.st != PFM_RUN ##1 s_r.st == PFM_RUN;
  endsequence

  chk_run_length: assert property (@(posedge clk) disable iff (!rst_n)
    s_start_run |-> (s_r.st == PFM_RUN) [*8]) // R7
    else $error("run ended early");
  chk_rezero_timer: assert property (@(posedge clk) disable iff (!rst_n)
    (rz_pulse && s_r.st != PFM_RUN && mon_en && !online_only_bit) |=>
      s_r.tmr == PERIOD && s_r.st == PFM_RUN) // R4
    else $error("rezero did not restart timer");
  chk_online_only: assert property (@(posedge clk) disable iff (!rst_n)
    (online_only_bit && s_r.st != PFM_RUN) |=> s_r.st != PFM_RUN) // R3
    else $error("off-line run in online-only mode");
  chk_wait_idle: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == PFM_WAIT && !idle_s && !rz_pulse) |=> s_r.st != PFM_RUN) // R6
    else $error("scheduled run started on busy bus");
  chk_reload: assert property (@(posedge clk) disable iff (!rst_n)
    (s_r.st == PFM_RUN ##1 s_r.st == PFM_IDLE) |-> s_r.tmr == PERIOD) // R17
    else $error("timer not reloaded after run");
  chk_sense: assert property (@(posedge clk) disable iff (!rst_n)
    sense_valid |-> sense_code == SENSE_CODE && sense_key == SENSE_KEY && s_r.fail) // R8
    else $error("wrong sense code");
  chk_done_enabled: assert property (@(posedge clk) disable iff (!rst_n)
    |attr_done |-> $past(mon_en)) // R1
    else $error("interval closed while disabled");
  chk_disable_report: assert property (@(posedge clk) disable iff (!rst_n)
    exceptions_disable_bit |-> !sense_valid) // R1
    else $error("report while disabled");

endmodule : pfm_top

// File: pfm_host_model.sv
// host adapter model: rezero pin, bus idle pin, failure store
`timescale 1ns/1ps
module pfm_host_model (
  // clock
  input  wire logic clk,
  // bench requests
  input  wire logic rezero_req,
  input  wire logic hold_busy,
  input  wire logic nv_clear,
  // device pins
  input  wire logic nv_fail_set,
  output logic      rezero_command,
  output logic      bus_idle,
  output logic      nv_fail_in
);
  logic [3:0] pin_cnt_r = 4'h0;
  logic       nv_r      = 1'b0;
  // pin high 4 cycles, then low at least 5 so each rezero is a clean edge
  always_ff @(posedge clk) begin
    if (pin_cnt_r != 4'h0) pin_cnt_r <= pin_cnt_r - 4'h1;
    else if (rezero_req) pin_cnt_r <= 4'h8;
  end
  assign rezero_command = pin_cnt_r > 4'h4;
  assign bus_idle       = !hold_busy;
  // no reset here: stands for non-volatile memory
  always_ff @(posedge clk) begin
    if (nv_clear) nv_r <= 1'b0;
    else if (nv_fail_set) nv_r <= 1'b1;
  end
  assign nv_fail_in = nv_r;
endmodule : pfm_host_model

// File: predictive_failure_monitor_tb_top.sv
// testbench of the predictive failure monitor
`timescale 1ns/1ps
module predictive_failure_monitor_tb_top;
  import pfm_pkg::*;
  // ****
  // setup
  // ****
  localparam int NA = 4;
  localparam int PER = 200;
  localparam int RUNF = 20;
  localparam int L = 4;
  localparam int T = 1;
  logic                 clk, rst_n, dis, onl, rep, rz_req, busy_h, nv_clr;
  logic                 rz, idle, nv_in, nv_set, run_busy, save_strobe, sense_valid;
  logic [7:0]           sense_key;
  logic [15:0]          sense_code;
  logic [TMR_W-1:0]     time_to_run, t0;
  logic [NA*HIST_W-1:0] history_out;
  logic [CNT_W-1:0]     ilen, ethr;
  logic [HIST_W-1:0]    pthr;
  logic [NA-1:0]        op, er;
  int err_count, samples_checked, seed, n, saves, s0;
  int ops[NA], errs[NA], hist[NA];

  pfm_top #(.N_ATTR(NA), .PERIOD(TMR_W'(PER)), .RUN_ONL(RUN_W'(RUNF)),
            .RUN_FULL(RUN_W'(RUNF))) dut (
    .clk(clk), .rst_n(rst_n), .exceptions_disable_bit(dis), .online_only_bit(onl),
    .report_enable(rep), .interval_len(ilen), .err_threshold(ethr),
    .pred_threshold(pthr), .rezero_command(rz), .bus_idle(idle), .op_event(op),
    .err_event(er), .nv_fail_in(nv_in), .nv_fail_set(nv_set), .run_busy(run_busy),
    .save_strobe(save_strobe), .time_to_run(time_to_run), .sense_valid(sense_valid),
    .sense_key(sense_key), .sense_code(sense_code), .history_out(history_out));
  pfm_host_model host (.clk(clk), .rezero_req(rz_req), .hold_busy(busy_h),
    .nv_clear(nv_clr), .nv_fail_set(nv_set), .rezero_command(rz), .bus_idle(idle),
    .nv_fail_in(nv_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // sampled off the launching edge so the pulse is seen settled
  always @(negedge clk) if (save_strobe === 1'b1) saves++;

  // ****
  // tasks
  // ****
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    samples_checked++;
    if (exp !== got) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  // bounded wait; a timeout is a mismatch
  task automatic wait_busy(logic lvl, int lim);
    n = 0;
    while (run_busy !== lvl) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("CHECK FAILED run_busy expected %0h seen timeout", lvl);
        finish_test();
      end
    end
  endtask : wait_busy
  function automatic int next_hist(int h, int e);
    return (e > T) ? h + 1 : ((h == 0) ? 0 : h - 1);
  endfunction : next_hist
  // one event cycle, one quiet cycle; model follows when upd set
  task automatic send(logic [NA-1:0] o, logic [NA-1:0] e, bit upd);
    op = o;
    er = e;
    @(negedge clk);
    op = '0;
    er = '0;
    @(negedge clk);
    if (upd) for (int g = 0; g < NA; g++) begin
      errs[g] += e[g];
      ops[g] += o[g];
      if (ops[g] == L) begin
        hist[g] = next_hist(hist[g], errs[g]);
        ops[g] = 0;
        errs[g] = 0;
      end
    end
  endtask : send
  task automatic check_hist;
    repeat (3) @(negedge clk);
    for (int g = 0; g < NA; g++)
      check("history", 64'(hist[g]), 64'(history_out[g*HIST_W+:HIST_W]));
  endtask : check_hist
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int g = 0; g < NA; g++) begin
      ops[g] = 0;
      errs[g] = 0;
      hist[g] = 0;
    end
  endtask : do_reset
  task automatic rezero;
    rz_req = 1'b1;
    @(negedge clk);
    rz_req = 1'b0;
  endtask : rezero

  // ****
  // main sequence
  // ****
  initial begin
    {dis, onl, rz_req, busy_h, op, er} = '0;
    {err_count, samples_checked, saves} = '0;
    seed = 32'h2B8DC27B;
    rep = 1'b1;
    ilen = 16'h0004;
    ethr = 16'h0001;
    pthr = 8'h00;
    nv_clr = 1'b1;
    do_reset();
    nv_clr = 1'b0;
    check("time_to_run", 64'(PER - 3), 64'(time_to_run));
    check("sense_valid", 64'(0), 64'(sense_valid));
    $display("test reset done");
    // threshold exactly met, error on terminal op
    for (int k = 0; k < 4; k++) send(4'hF, (k == 0) ? 4'h7 : (k == 1) ? 4'h1 : (k == 3) ? 4'h4 : 4'h0, 1);
    check_hist();
    repeat (200) send(4'($random(seed)), 4'($random(seed)), 1);
    check_hist();
    $display("test traffic done");
    dis = 1'b1;
    s0 = saves;
    rezero();
    repeat (20) send(4'hF, 4'hF, 0);
    dis = 1'b0;
    check("saves", 64'(s0), 64'(saves));
    check_hist();
    $display("test disable done");
    s0 = saves;
    rezero();
    wait_busy(1'b1, 10);
    check("timer restart", 64'(1), 64'(time_to_run >= PER - 1));
    repeat (8) @(negedge clk);
    rezero();
    wait_busy(1'b0, RUNF + 4);
    check("run length", 64'(1), 64'(n + 9 >= RUNF - 1 && n + 9 <= RUNF + 2));
    repeat (15) @(negedge clk);
    check("saves", 64'(s0 + 1), 64'(saves));
    $display("test rezero done");
    onl = 1'b1;
    s0 = saves;
    rezero();
    repeat (250) @(negedge clk);
    check("saves", 64'(s0), 64'(saves));
    busy_h = 1'b1;
    onl = 1'b0;
    n = 0;
    while (time_to_run !== '0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (time_to_run !== '0) begin
      err_count++;
      $display("CHECK FAILED time_to_run expected 0 seen timeout");
      finish_test();
    end
    repeat (20) @(negedge clk);
    check("run_busy", 64'(0), 64'(run_busy));
    busy_h = 1'b0;
    wait_busy(1'b1, 10);
    wait_busy(1'b0, RUNF + 4);
    repeat (2) @(negedge clk);
    check("reload", 64'(1), 64'(time_to_run >= PER - 4));
    t0 = time_to_run;
    repeat (10) @(negedge clk);
    check("time_to_run", 64'(t0 - 10), 64'(time_to_run));
    $display("test schedule done");
    nv_clr = 1'b1;
    do_reset();
    nv_clr = 1'b0;
    pthr = 8'h02;
    repeat (4) send(4'h1, 4'h1, 1);
    check_hist();
    check("sense_valid", 64'(0), 64'(sense_valid));
    repeat (4) send(4'h1, 4'h1, 1);
    check_hist();
    check("sense_valid", 64'(1), 64'(sense_valid));
    check("sense", 64'({SENSE_KEY, SENSE_CODE}), 64'({sense_key, sense_code}));
    check("nv store", 64'(1), 64'(nv_in));
    rep = 1'b0;
    repeat (2) @(negedge clk);
    check("sense_valid", 64'(0), 64'(sense_valid));
    rep = 1'b1;
    do_reset();
    repeat (3) @(negedge clk);
    check("sense_valid", 64'(1), 64'(sense_valid));
    $display("test predict done");
    finish_test();
  end
endmodule : predictive_failure_monitor_tb_top
